// *** pin_mux_regs.svh ***
// Register indices, field positions, reset values and bus widths for the pin multiplexer
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PM_IDX_W 14
`define PM_IDX_BUS_SELECTION 14'h1C00
`define PM_IDX_SERIAL_INHIBIT 14'h1C17
`define PM_IDX_PARALLEL_INHIBIT 14'h1C19
`define PM_IDX_BYTE_EN_INHIBIT 14'h1C4F
`define PM_IDX_CONTROL_INHIBIT 14'h1C50

// ----------------------------------------------------------------------------
// Bus selection fields
// ----------------------------------------------------------------------------
`define PM_PP_MODE_LSB 12
`define PM_SP1_MODE_LSB 10
`define PM_SP0_MODE_LSB 8
`define PM_CLK_SRC_BIT 15
`define PM_BUS_SEL_MASK 16'hFF00
`define PM_BUS_SEL_RESET 16'h1000
`define PM_INHIBIT_RESET 16'h0000

// ----------------------------------------------------------------------------
// Pin counts
// ----------------------------------------------------------------------------
`define PM_PP_PINS 28
`define PM_SP_PINS 6
`define PM_ALL_PINS 40

`endif

// *** pin_mux_pkg.sv ***
// Types for the pin multiplexer mode fields
package pin_mux_pkg;
  typedef logic [2:0] pp_mode_t;
  typedef logic [1:0] sp_mode_t;
  localparam pp_mode_t PP_HOST = 3'h0;
  localparam pp_mode_t PP_GPIO_UP = 3'h2;
  localparam sp_mode_t SP_GPIO = 2'h2;
  localparam sp_mode_t SP_ALT = 2'h1;
  localparam sp_mode_t SP_BSP = 2'h3;
endpackage

// *** pin_mux_reg.sv ***
// Software register with byte-lane writes and a mask of implemented bits
`timescale 1ns/1ps
module pin_mux_reg #(
  parameter int WIDTH = 16,
  parameter logic [15:0] RESET = 16'h0000,
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] q_o
);
  generate
    if (WIDTH != 16) begin : g_bad
      $error("pin_mux_reg supports only 16-bit registers");
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RESET & MASK;
    end else if (wr_i) begin
      if (sel_i[0]) begin
        q_o[7:0] <= dat_i[7:0] & MASK[7:0];
      end
      if (sel_i[1]) begin
        q_o[15:8] <= dat_i[15:8] & MASK[15:8];
      end
    end
  end
endmodule

// *** pin_mux_pad.sv ***
// Output flops for one pad: level, drive enable and pull enable
`timescale 1ns/1ps
module pin_mux_pad (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic out_d_i,
  input wire logic oe_d_i,
  input wire logic inhibit_i,
  output logic out_o,
  output logic oe_o,
  output logic pull_en_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
      oe_o <= 1'b0;
      pull_en_o <= 1'b1;
    end else begin
      out_o <= out_d_i;
      oe_o <= oe_d_i;
      // Pull follows its own bit, whatever function owns the pin
      pull_en_o <= ~inhibit_i;
    end
  end
endmodule

// *** pin_mux.sv ***
// Peripheral pin multiplexer with Wishbone register access
`timescale 1ns/1ps
`include "pin_mux_regs.svh"
module pin_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [27:0] host_out_i,
  input wire logic [27:0] host_oe_i,
  output logic [27:0] host_in_o,
  input wire logic [6:0] mem_out_i,
  input wire logic [6:0] spi_out_i,
  input wire logic [6:0] spi_oe_i,
  output logic [6:0] spi_in_o,
  input wire logic [31:0] general_io_out_i,
  input wire logic [31:0] general_io_oe_i,
  output logic [31:0] general_io_in_o,
  input wire logic [3:0] uart_out_i,
  input wire logic [3:0] uart_oe_i,
  output logic [3:0] uart_in_o,
  input wire logic [3:0] i2s2_out_i,
  input wire logic [3:0] i2s2_oe_i,
  output logic [3:0] i2s2_in_o,
  input wire logic [3:0] i2s3_out_i,
  input wire logic [3:0] i2s3_oe_i,
  output logic [3:0] i2s3_in_o,
  input wire logic [3:0] i2s0_out_i,
  input wire logic [3:0] i2s0_oe_i,
  output logic [3:0] i2s0_in_o,
  input wire logic [5:0] card_port0_out_i,
  input wire logic [5:0] card_port0_oe_i,
  output logic [5:0] card_port0_in_o,
  input wire logic [5:0] card_port1_out_i,
  input wire logic [5:0] card_port1_oe_i,
  output logic [5:0] card_port1_in_o,
  input wire logic [5:0] multichannel_spi_out_i,
  input wire logic [5:0] multichannel_spi_oe_i,
  output logic [5:0] multichannel_spi_in_o,
  input wire logic [5:0] buffered_serial_port_out_i,
  input wire logic [5:0] buffered_serial_port_oe_i,
  output logic [5:0] buffered_serial_port_in_o,
  output logic receive_clock_or_source_o,
  input wire logic [27:0] pp_pad_in_i,
  output logic [27:0] pp_pad_out_o,
  output logic [27:0] pp_pad_oe_o,
  output logic [27:0] pp_pad_pull_en_o,
  input wire logic [5:0] sp1_pad_in_i,
  output logic [5:0] sp1_pad_out_o,
  output logic [5:0] sp1_pad_oe_o,
  output logic [5:0] sp1_pad_pull_en_o,
  input wire logic [5:0] sp0_pad_in_i,
  output logic [5:0] sp0_pad_out_o,
  output logic [5:0] sp0_pad_oe_o,
  output logic [5:0] sp0_pad_pull_en_o
);
  import pin_mux_pkg::*;

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  localparam int SPI_UP [4] = '{0, 3, 1, 2};
  logic [`PM_IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic [15:0] bus_sel_q;
  logic [15:0] ser_inh_q;
  logic [15:0] par_inh_q;
  logic [15:0] be_inh_q;
  logic [15:0] ctl_inh_q;
  logic [15:0] rd_d;

  assign idx = wb_adr_i[15:2];
  assign req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr = req & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_comb begin
    if (idx == `PM_IDX_BUS_SELECTION) begin
      rd_d = bus_sel_q;
    end else if (idx == `PM_IDX_SERIAL_INHIBIT) begin
      rd_d = ser_inh_q;
    end else if (idx == `PM_IDX_PARALLEL_INHIBIT) begin
      rd_d = par_inh_q;
    end else if (idx == `PM_IDX_BYTE_EN_INHIBIT) begin
      rd_d = be_inh_q;
    end else if (idx == `PM_IDX_CONTROL_INHIBIT) begin
      rd_d = ctl_inh_q;
    end else begin
      rd_d = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= {16'h0000, rd_d};
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Only this register steers pin functions
  pin_mux_reg #(.WIDTH(16), .RESET(`PM_BUS_SEL_RESET), .MASK(`PM_BUS_SEL_MASK)) u_bus_sel (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr && idx == `PM_IDX_BUS_SELECTION),
    .sel_i(wb_sel_i[1:0]), .dat_i(wb_dat_i[15:0]), .q_o(bus_sel_q));
  pin_mux_reg #(.WIDTH(16), .RESET(`PM_INHIBIT_RESET), .MASK(16'hFFFF)) u_ser_inh (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr && idx == `PM_IDX_SERIAL_INHIBIT),
    .sel_i(wb_sel_i[1:0]), .dat_i(wb_dat_i[15:0]), .q_o(ser_inh_q));
  pin_mux_reg #(.WIDTH(16), .RESET(`PM_INHIBIT_RESET), .MASK(16'hFFFF)) u_par_inh (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr && idx == `PM_IDX_PARALLEL_INHIBIT),
    .sel_i(wb_sel_i[1:0]), .dat_i(wb_dat_i[15:0]), .q_o(par_inh_q));
  pin_mux_reg #(.WIDTH(16), .RESET(`PM_INHIBIT_RESET), .MASK(16'hFFFF)) u_be_inh (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr && idx == `PM_IDX_BYTE_EN_INHIBIT),
    .sel_i(wb_sel_i[1:0]), .dat_i(wb_dat_i[15:0]), .q_o(be_inh_q));
  pin_mux_reg #(.WIDTH(16), .RESET(`PM_INHIBIT_RESET), .MASK(16'hFFFF)) u_ctl_inh (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr && idx == `PM_IDX_CONTROL_INHIBIT),
    .sel_i(wb_sel_i[1:0]), .dat_i(wb_dat_i[15:0]), .q_o(ctl_inh_q));

  pp_mode_t parallel_port_mode;
  sp_mode_t serial_port1_mode;
  sp_mode_t serial_port0_mode;
  logic clk_src_sel;
  assign parallel_port_mode = bus_sel_q[`PM_PP_MODE_LSB+:3];
  assign serial_port1_mode = bus_sel_q[`PM_SP1_MODE_LSB+:2];
  assign serial_port0_mode = bus_sel_q[`PM_SP0_MODE_LSB+:2];
  assign clk_src_sel = bus_sel_q[`PM_CLK_SRC_BIT];

  // --------------------------------------------------------------------------
  // Parallel port routing
  // --------------------------------------------------------------------------
  logic [27:0] pp_o;
  logic [27:0] pp_e;
  logic [27:0] host_d;
  logic [6:0] spi_d;
  logic [31:0] gio_d;
  logic [3:0] uart_d;
  logic [3:0] i2s2_d;
  logic [3:0] i2s3_d;

  always_comb begin
    pp_o = '0;
    pp_e = '0;
    host_d = '0;
    spi_d = '0;
    gio_d = '0;
    uart_d = '0;
    i2s2_d = '0;
    i2s3_d = '0;
    if (parallel_port_mode == PP_HOST) begin
      pp_o = host_out_i;
      pp_e = host_oe_i;
      host_d = pp_pad_in_i;
    end else if (parallel_port_mode != 3'h7) begin
      pp_o[27:21] = mem_out_i;
      pp_e[27:21] = 7'h7F;
      // Modes 010-101 leave the low group undriven
      if (parallel_port_mode == 3'h1 || parallel_port_mode == 3'h6) begin
        for (int k = 0; k < 3; k++) begin
          pp_o[k] = spi_out_i[k];
          pp_e[k] = spi_oe_i[k];
          spi_d[k] = pp_pad_in_i[k];
        end
        for (int k = 0; k < 4; k++) begin
          pp_o[17+k] = spi_out_i[3+k];
          pp_e[17+k] = spi_oe_i[3+k];
          spi_d[3+k] = pp_pad_in_i[17+k];
        end
        for (int k = 0; k < 6; k++) begin
          pp_o[3+k] = general_io_out_i[12+k];
          pp_e[3+k] = general_io_oe_i[12+k];
          gio_d[12+k] = pp_pad_in_i[3+k];
        end
      end
      for (int k = 0; k < 4; k++) begin
        case (parallel_port_mode)
          3'h1, 3'h4, 3'h6: begin
            pp_o[9+k] = i2s2_out_i[k];
            pp_e[9+k] = i2s2_oe_i[k];
            i2s2_d[k] = pp_pad_in_i[9+k];
          end
          3'h3, 3'h5: begin
            pp_o[9+k] = spi_out_i[SPI_UP[k]];
            pp_e[9+k] = spi_oe_i[SPI_UP[k]];
            spi_d[SPI_UP[k]] = pp_pad_in_i[9+k];
          end
          default: begin
          end
        endcase
        case (parallel_port_mode)
          3'h1, 3'h4, 3'h5: begin
            pp_o[13+k] = uart_out_i[k];
            pp_e[13+k] = uart_oe_i[k];
            uart_d[k] = pp_pad_in_i[13+k];
          end
          3'h3, 3'h6: begin
            pp_o[13+k] = i2s3_out_i[k];
            pp_e[13+k] = i2s3_oe_i[k];
            i2s3_d[k] = pp_pad_in_i[13+k];
          end
          default: begin
          end
        endcase
      end
      if (parallel_port_mode == PP_GPIO_UP) begin
        for (int k = 0; k < 8; k++) begin
          pp_o[9+k] = general_io_out_i[(k < 3) ? 18 + k : 24 + k];
          pp_e[9+k] = general_io_oe_i[(k < 3) ? 18 + k : 24 + k];
          gio_d[(k < 3) ? 18 + k : 24 + k] = pp_pad_in_i[9+k];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial port routing
  // --------------------------------------------------------------------------
  logic [5:0] sp1_o;
  logic [5:0] sp1_e;
  logic [5:0] sp0_o;
  logic [5:0] sp0_e;
  logic [5:0] card1_d;
  logic [5:0] multichannel_spi_d;
  logic [5:0] card0_d;
  logic [3:0] i2s0_d;
  logic [5:0] bsp_d;
  logic clks_d;
  logic [5:0] sgio_d;

  always_comb begin
    sp1_o = '0;
    sp1_e = '0;
    sp0_o = '0;
    sp0_e = '0;
    card1_d = '0;
    multichannel_spi_d = '0;
    card0_d = '0;
    i2s0_d = '0;
    bsp_d = '0;
    clks_d = 1'b0;
    sgio_d = '0;
    case (serial_port1_mode)
      2'h0: begin
        sp1_o = card_port1_out_i;
        sp1_e = card_port1_oe_i;
        card1_d = sp1_pad_in_i;
      end
      SP_ALT: begin
        sp1_o = multichannel_spi_out_i;
        sp1_e = multichannel_spi_oe_i;
        multichannel_spi_d = sp1_pad_in_i;
      end
      SP_GPIO: begin
        sp1_o = general_io_out_i[11:6];
        sp1_e = general_io_oe_i[11:6];
      end
      default: begin
      end
    endcase
    case (serial_port0_mode)
      2'h0: begin
        sp0_o = card_port0_out_i;
        sp0_e = card_port0_oe_i;
        card0_d = sp0_pad_in_i;
      end
      SP_ALT: begin
        sp0_o = {general_io_out_i[5:4], i2s0_out_i};
        sp0_e = {general_io_oe_i[5:4], i2s0_oe_i};
        i2s0_d = sp0_pad_in_i[3:0];
        sgio_d[5:4] = sp0_pad_in_i[5:4];
      end
      SP_GPIO: begin
        sp0_o = general_io_out_i[5:0];
        sp0_e = general_io_oe_i[5:0];
        sgio_d = sp0_pad_in_i;
      end
      default: begin
        sp0_o = buffered_serial_port_out_i;
        sp0_e = buffered_serial_port_oe_i;
        bsp_d = sp0_pad_in_i;
        // As clock source the last pin is input only
        if (clk_src_sel) begin
          sp0_e[5] = 1'b0;
          bsp_d[5] = 1'b0;
          clks_d = sp0_pad_in_i[5];
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Returned inputs, one flop each
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_in_o <= '0;
      spi_in_o <= '0;
      general_io_in_o <= '0;
      uart_in_o <= '0;
      i2s2_in_o <= '0;
      i2s3_in_o <= '0;
      i2s0_in_o <= '0;
      card_port0_in_o <= '0;
      card_port1_in_o <= '0;
      multichannel_spi_in_o <= '0;
      buffered_serial_port_in_o <= '0;
      receive_clock_or_source_o <= 1'b0;
    end else begin
      host_in_o <= host_d;
      spi_in_o <= spi_d;
      general_io_in_o <= {gio_d[31:12], (serial_port1_mode == SP_GPIO) ? sp1_pad_in_i : 6'h00, sgio_d};
      uart_in_o <= uart_d;
      i2s2_in_o <= i2s2_d;
      i2s3_in_o <= i2s3_d;
      i2s0_in_o <= i2s0_d;
      card_port0_in_o <= card0_d;
      card_port1_in_o <= card1_d;
      multichannel_spi_in_o <= multichannel_spi_d;
      buffered_serial_port_in_o <= bsp_d;
      receive_clock_or_source_o <= clks_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pads
  // --------------------------------------------------------------------------
  logic [39:0] all_o;
  logic [39:0] all_e;
  logic [39:0] all_inh;
  logic [39:0] pad_out_q;
  logic [39:0] pad_oe_q;
  logic [39:0] pad_pull_q;

  assign all_o = {sp0_o, sp1_o, pp_o};
  assign all_e = {sp0_e, sp1_e, pp_e};
  assign all_inh = {ser_inh_q[5:0], ser_inh_q[13:8],
                    ctl_inh_q[1], ctl_inh_q[5], ctl_inh_q[4], ctl_inh_q[2], ctl_inh_q[3],
                    be_inh_q[8], be_inh_q[7], ctl_inh_q[11:8], par_inh_q, ctl_inh_q[12]};

  generate
    for (genvar p = 0; p < `PM_ALL_PINS; p++) begin : g_pad
      pin_mux_pad u_pad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .out_d_i(all_o[p]),
        .oe_d_i(all_e[p]),
        .inhibit_i(all_inh[p]),
        .out_o(pad_out_q[p]),
        .oe_o(pad_oe_q[p]),
        .pull_en_o(pad_pull_q[p])
      );
    end
  endgenerate

  assign pp_pad_out_o = pad_out_q[27:0];
  assign pp_pad_oe_o = pad_oe_q[27:0];
  assign pp_pad_pull_en_o = pad_pull_q[27:0];
  assign sp1_pad_out_o = pad_out_q[33:28];
  assign sp1_pad_oe_o = pad_oe_q[33:28];
  assign sp1_pad_pull_en_o = pad_pull_q[33:28];
  assign sp0_pad_out_o = pad_out_q[39:34];
  assign sp0_pad_oe_o = pad_oe_q[39:34];
  assign sp0_pad_pull_en_o = pad_pull_q[39:34];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_WB_ACK: assert property (s_wb_req |=> s_wb_answer) else $error("ack not a single cycle after request");
  AST_SEL_WRITE: assert property (wr && idx == `PM_IDX_BUS_SELECTION && wb_sel_i[1]
    |=> parallel_port_mode == $past(wb_dat_i[14:12])) else $error("mode write not taken");
  AST_PP_RESET: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
    |=> parallel_port_mode == 3'h1 && serial_port0_mode == 2'h0) else $error("bad mode after reset");
  AST_PP_HOST: assert property (parallel_port_mode == PP_HOST
    |=> pp_pad_oe_o == $past(host_oe_i) && pp_pad_out_o == $past(host_out_i)) else $error("host not routed");
  AST_MEM_DRIVE: assert property (parallel_port_mode != PP_HOST && parallel_port_mode != 3'h7
    |=> pp_pad_oe_o[27:21] == 7'h7F && pp_pad_out_o[27:21] == $past(mem_out_i)) else $error("memory pins wrong");
  AST_RESERVED: assert property (parallel_port_mode inside {3'h2, 3'h3, 3'h4, 3'h5}
    |=> pp_pad_oe_o[8:0] == 9'h000 && pp_pad_oe_o[20:17] == 4'h0) else $error("reserved pins driven");
  AST_UP_GPIO: assert property (parallel_port_mode == PP_GPIO_UP |=>
    pp_pad_out_o[16:9] == $past({general_io_out_i[31:27], general_io_out_i[20:18]})) else $error("upper gpio");
  AST_SP1_GPIO: assert property (serial_port1_mode == SP_GPIO
    |=> sp1_pad_out_o == $past(general_io_out_i[11:6])) else $error("serial port 1 gpio wrong");
  AST_SP0_I2S: assert property (serial_port0_mode == SP_ALT
    |=> sp0_pad_oe_o[3:0] == $past(i2s0_oe_i)) else $error("serial port 0 i2s wrong");
  AST_CLK_SRC: assert property (serial_port0_mode == SP_BSP && clk_src_sel
    |=> !sp0_pad_oe_o[5] && receive_clock_or_source_o == $past(sp0_pad_in_i[5])) else $error("clock source");
  AST_SP1_PULL: assert property (##1 sp1_pad_pull_en_o == ~$past(ser_inh_q[13:8])) else $error("sp1 pull");
  AST_SP0_PULL: assert property (##1 sp0_pad_pull_en_o == ~$past(ser_inh_q[5:0])) else $error("sp0 pull");
endmodule

// *** pad_far_end.sv ***
// Board-side model of the package pads for the pin multiplexer bench
`timescale 1ns/1ps
module pad_far_end (
  input wire logic [27:0] pp_out_i,
  input wire logic [27:0] pp_oe_i,
  input wire logic [27:0] pp_ext_i,
  output logic [27:0] pp_in_o,
  input wire logic [5:0] sp1_out_i,
  input wire logic [5:0] sp1_oe_i,
  input wire logic [5:0] sp1_ext_i,
  output logic [5:0] sp1_in_o,
  input wire logic [5:0] sp0_out_i,
  input wire logic [5:0] sp0_oe_i,
  input wire logic [5:0] sp0_ext_i,
  output logic [5:0] sp0_in_o
);
  // A pin the chip drives reads back its own level; a released pin takes the board level,
  // which the bench sets per pin and which can match the last driven value, as on sp0 pin 5
  assign pp_in_o = (pp_oe_i & pp_out_i) | (~pp_oe_i & pp_ext_i);
  assign sp1_in_o = (sp1_oe_i & sp1_out_i) | (~sp1_oe_i & sp1_ext_i);
  assign sp0_in_o = (sp0_oe_i & sp0_out_i) | (~sp0_oe_i & sp0_ext_i);
endmodule

// *** peripheral_pin_multiplexer_bench.sv ***
// Self-checking bench for the peripheral pin multiplexer
`timescale 1ns/1ps
`include "pin_mux_regs.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", what, (exp), (got)); end end
module peripheral_pin_multiplexer_bench;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
  logic [27:0] host_out_i = 28'hA5C3E1F, host_oe_i = 28'hFFFFFFF, host_in_o, pp_ext = 28'h5A3C0F1;
  logic [27:0] pp_pad_in_i, pp_pad_out_o, pp_pad_oe_o, pp_pad_pull_en_o;
  logic [6:0] mem_out_i = 7'h5A, spi_out_i = 7'h4B, spi_oe_i = 7'h7F, spi_in_o;
  logic [31:0] general_io_out_i = 32'h9E3779B9, general_io_oe_i = 32'hFFFFFFFF, general_io_in_o;
  logic [3:0] uart_out_i = 4'h9, uart_oe_i = 4'hF, uart_in_o, i2s2_out_i = 4'h6, i2s2_oe_i = 4'hF, i2s2_in_o;
  logic [3:0] i2s3_out_i = 4'hC, i2s3_oe_i = 4'hF, i2s3_in_o, i2s0_out_i = 4'h3, i2s0_oe_i = 4'hF, i2s0_in_o;
  logic [5:0] card_port0_out_i = 6'h2D, card_port0_oe_i = 6'h3F, card_port0_in_o, sp1_ext = 6'h15;
  logic [5:0] card_port1_out_i = 6'h1B, card_port1_oe_i = 6'h3F, card_port1_in_o, sp0_ext = 6'h2A;
  logic [5:0] multichannel_spi_out_i = 6'h35, multichannel_spi_oe_i = 6'h3F, multichannel_spi_in_o;
  logic [5:0] buffered_serial_port_out_i = 6'h27, buffered_serial_port_oe_i = 6'h3F, buffered_serial_port_in_o;
  logic [5:0] sp1_pad_in_i, sp1_pad_out_o, sp1_pad_oe_o, sp1_pad_pull_en_o;
  logic [5:0] sp0_pad_in_i, sp0_pad_out_o, sp0_pad_oe_o, sp0_pad_pull_en_o;
  logic receive_clock_or_source_o;
  int cycles = 0;
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [13:0] INH_IDX [4] = '{`PM_IDX_SERIAL_INHIBIT, `PM_IDX_PARALLEL_INHIBIT,
    `PM_IDX_BYTE_EN_INHIBIT, `PM_IDX_CONTROL_INHIBIT};
  localparam logic [15:0] INH_VAL [4] = '{16'h2A15, 16'h9C3A, 16'h0180, 16'h1A36};

  pin_mux dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .host_out_i, .host_oe_i, .host_in_o, .mem_out_i, .spi_out_i, .spi_oe_i, .spi_in_o,
    .general_io_out_i, .general_io_oe_i, .general_io_in_o, .uart_out_i, .uart_oe_i, .uart_in_o,
    .i2s2_out_i, .i2s2_oe_i, .i2s2_in_o, .i2s3_out_i, .i2s3_oe_i, .i2s3_in_o, .i2s0_out_i, .i2s0_oe_i, .i2s0_in_o,
    .card_port0_out_i, .card_port0_oe_i, .card_port0_in_o, .card_port1_out_i, .card_port1_oe_i, .card_port1_in_o,
    .multichannel_spi_out_i, .multichannel_spi_oe_i, .multichannel_spi_in_o, .buffered_serial_port_out_i,
    .buffered_serial_port_oe_i, .buffered_serial_port_in_o, .receive_clock_or_source_o,
    .pp_pad_in_i, .pp_pad_out_o, .pp_pad_oe_o, .pp_pad_pull_en_o, .sp1_pad_in_i, .sp1_pad_out_o,
    .sp1_pad_oe_o, .sp1_pad_pull_en_o, .sp0_pad_in_i, .sp0_pad_out_o, .sp0_pad_oe_o, .sp0_pad_pull_en_o
  );
  pad_far_end board (
    .pp_out_i(pp_pad_out_o), .pp_oe_i(pp_pad_oe_o), .pp_ext_i(pp_ext), .pp_in_o(pp_pad_in_i),
    .sp1_out_i(sp1_pad_out_o), .sp1_oe_i(sp1_pad_oe_o), .sp1_ext_i(sp1_ext), .sp1_in_o(sp1_pad_in_i),
    .sp0_out_i(sp0_pad_out_o), .sp0_oe_i(sp0_pad_oe_o), .sp0_ext_i(sp0_ext), .sp0_in_o(sp0_pad_in_i)
  );

  always #2 clk_i = ~clk_i;
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [13:0] idx, input logic [15:0] wd,
                         input logic [1:0] sel, output logic [15:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= {2'b00, sel};
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Expected parallel pads as {drive enables, levels} with every peripheral enable high
  function automatic logic [55:0] pp_exp(input logic [2:0] m);
    logic [27:0] o, e;
    o = 28'h0000000;
    e = 28'h0000000;
    if (m == 3'h0) begin
      o = host_out_i;
      e = 28'hFFFFFFF;
    end else if (m != 3'h7) begin
      o[27:21] = mem_out_i;
      e[27:9] = 19'h7FFFF;
      if (m == 3'h1 || m == 3'h6) begin
        o[8:0] = {general_io_out_i[17:12], spi_out_i[2:0]};
        o[20:17] = spi_out_i[6:3];
        e[8:0] = 9'h1FF;
      end else e[20:17] = 4'h0;
      case (m)
        3'h1, 3'h4: o[16:9] = {uart_out_i, i2s2_out_i};
        3'h2: o[16:9] = {general_io_out_i[31:27], general_io_out_i[20:18]};
        3'h3: o[16:9] = {i2s3_out_i, spi_out_i[2], spi_out_i[1], spi_out_i[3], spi_out_i[0]};
        3'h5: o[16:9] = {uart_out_i, spi_out_i[2], spi_out_i[1], spi_out_i[3], spi_out_i[0]};
        default: o[16:9] = {i2s3_out_i, i2s2_out_i};
      endcase
    end
    return {e, o};
  endfunction

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic check_reset_state();
    logic [55:0] pe;
    pe = pp_exp(3'h1);
    `CHK("pp oe after reset", pe[55:28], pp_pad_oe_o)
    `CHK("pp out after reset", pe[27:0], pp_pad_out_o & pe[55:28])
    `CHK("sp1 out after reset", card_port1_out_i, sp1_pad_out_o)
    `CHK("sp0 out after reset", card_port0_out_i, sp0_pad_out_o)
    `CHK("pull after reset", 28'hFFFFFFF, pp_pad_pull_en_o)
  endtask

  task automatic check_registers();
    logic [15:0] rd;
    wb_xfer(1'b0, `PM_IDX_BUS_SELECTION, 16'h0000, 2'b11, rd);
    `CHK("bus selection reset", 16'h1000, rd)
    wb_xfer(1'b1, `PM_IDX_SERIAL_INHIBIT, 16'h2A15, 2'b01, rd);
    wb_xfer(1'b0, `PM_IDX_SERIAL_INHIBIT, 16'h0000, 2'b11, rd);
    `CHK("low lane write", 16'h0015, rd)
    for (int i = 0; i < 4; i++) wb_xfer(1'b1, INH_IDX[i], INH_VAL[i], 2'b11, rd);
    for (int i = 0; i < 4; i++) begin
      wb_xfer(1'b0, INH_IDX[i], 16'h0000, 2'b11, rd);
      `CHK("inhibit readback", INH_VAL[i], rd)
    end
    wb_xfer(1'b1, 14'h0001, 16'hFFFF, 2'b11, rd);
    wb_xfer(1'b0, 14'h0001, 16'h0000, 2'b11, rd);
    `CHK("unmapped read", 16'h0000, rd)
    wb_xfer(1'b1, `PM_IDX_BUS_SELECTION, 16'hFFFF, 2'b11, rd);
    wb_xfer(1'b0, `PM_IDX_BUS_SELECTION, 16'h0000, 2'b11, rd);
    `CHK("bus selection fields", 16'hFF00, rd)
  endtask

  // Runs in undefined parallel mode: pulls must ignore the selected function
  task automatic check_pulls();
    logic [15:0] s, p, b, c;
    repeat (3) @(posedge clk_i);
    s = INH_VAL[0];
    p = INH_VAL[1];
    b = INH_VAL[2];
    c = INH_VAL[3];
    `CHK("sp1 pull", ~s[13:8], sp1_pad_pull_en_o)
    `CHK("sp0 pull", ~s[5:0], sp0_pad_pull_en_o)
    `CHK("pp pull", ~{c[1], c[5], c[4], c[2], c[3], b[8], b[7], c[11:8], p, c[12]}, pp_pad_pull_en_o)
  endtask

  task automatic check_modes();
    logic [15:0] rd;
    logic [55:0] pe;
    logic [5:0] s1, s0, e1;
    // Peripheral drive held still across each remap, as if each were reset
    for (int m = 0; m < 8; m++) begin
      wb_xfer(1'b1, `PM_IDX_BUS_SELECTION, {1'b0, 3'(m), 2'(m), 2'(m), 8'h00}, 2'b11, rd);
      repeat (3) @(posedge clk_i);
      pe = pp_exp(3'(m));
      case (m % 4)
        0: {s1, s0} = {card_port1_out_i, card_port0_out_i};
        1: {s1, s0} = {multichannel_spi_out_i, general_io_out_i[5:4], i2s0_out_i};
        2: {s1, s0} = {general_io_out_i[11:6], general_io_out_i[5:0]};
        default: {s1, s0} = {6'h00, buffered_serial_port_out_i};
      endcase
      e1 = (m % 4 == 3) ? 6'h00 : 6'h3F;
      `CHK("pp oe", pe[55:28], pp_pad_oe_o)
      `CHK("pp out", pe[27:0], pp_pad_out_o & pe[55:28])
      `CHK("sp1 oe", e1, sp1_pad_oe_o)
      `CHK("sp1 out", s1, sp1_pad_out_o & e1)
      `CHK("sp0 oe", 6'h3F, sp0_pad_oe_o)
      `CHK("sp0 out", s0, sp0_pad_out_o)
      `CHK("multichannel_spi in", (m % 4 == 1) ? multichannel_spi_out_i : 6'h00, multichannel_spi_in_o)
      `CHK("uart in", (m inside {1, 4, 5}) ? uart_out_i : 4'h0, uart_in_o)
    end
  endtask

  task automatic check_host_input();
    logic [15:0] rd;
    host_oe_i <= 28'h0000000;
    wb_xfer(1'b1, `PM_IDX_BUS_SELECTION, 16'h0000, 2'b11, rd);
    repeat (3) @(posedge clk_i);
    `CHK("host released", 28'h0000000, pp_pad_oe_o)
    `CHK("host input", pp_ext, host_in_o)
    host_oe_i <= 28'hFFFFFFF;
  endtask

  task automatic check_clock_source();
    logic [15:0] rd;
    buffered_serial_port_oe_i <= 6'h1F;
    wb_xfer(1'b1, `PM_IDX_BUS_SELECTION, 16'h8300, 2'b11, rd);
    repeat (3) @(posedge clk_i);
    `CHK("clock source", sp0_ext[5], receive_clock_or_source_o)
    wb_xfer(1'b1, `PM_IDX_BUS_SELECTION, 16'h0300, 2'b11, rd);
    repeat (3) @(posedge clk_i);
    `CHK("receive clock", 1'b0, receive_clock_or_source_o)
    `CHK("receive clock in", sp0_ext[5], buffered_serial_port_in_o[5])
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_reset_state();
    check_registers();
    check_pulls();
    check_modes();
    check_host_input();
    check_clock_source();
    report_and_stop();
  end
endmodule
